// >>> hw/dsadc_regs.vh
// Purpose: constants for the dual-slope converter control block
// Assumes: 10 MHz system clock, 32 kHz phase tick
// Notes: register map is a plain address/strobe port
`ifndef DSADC_REGS_VH
`define DSADC_REGS_VH

// ************************************
// register offsets
// ************************************
`define DSADC_OFF_CTRL 4'h0
`define DSADC_OFF_SEL 4'h1
`define DSADC_OFF_START 4'h2
`define DSADC_OFF_STATUS 4'h3
`define DSADC_OFF_RESULT 4'h4

// ************************************
// field positions
// ************************************
`define DSADC_CTRL_REF_EN 0
`define DSADC_CTRL_REF_ADJ 1
`define DSADC_CTRL_RES_LO 2
`define DSADC_CTRL_RES_HI 3
`define DSADC_SEL_TERM_LSB 0
`define DSADC_SEL_TYPE_LSB 5
`define DSADC_ST_BUSY 0
`define DSADC_ST_DONE 1
`define DSADC_ST_POL 2
`define DSADC_ST_PH_LSB 3

// ************************************
// reset values
// ************************************
`define DSADC_CTRL_RST 4'h0
`define DSADC_SEL_RST 9'h000
`define DSADC_TERM_RST 5'h00
`define DSADC_TYPE_RST 4'h0

// ************************************
// resolution counts per code
// ************************************
`define DSADC_RES_CNT0 13'h1998
`define DSADC_RES_CNT1 13'h0ccc
`define DSADC_RES_CNT2 13'h0666
`define DSADC_RES_CNT3 13'h0334

// ************************************
// timing
// ************************************
`define DSADC_CLK_HZ 10000000
`define DSADC_TICK_HZ 32768
`define DSADC_TICK_DIV (`DSADC_CLK_HZ / `DSADC_TICK_HZ)

`endif

// >>> hw/dsadc_phase_cnt.v
// Purpose: phase counter running on the 32 kHz tick
// Assumes: tick is a one-cycle pulse
// Notes: counts from zero on clear, flags terminal value
`timescale 1ns/1ps
module dsadc_phase_cnt #(
	parameter WIDTH = 13
) (
	input wire clk, // system clock
	input wire sys_rst, // sync reset, high
	input wire clr, // restart count at zero
	input wire tick, // 32 kHz tick pulse
	input wire [WIDTH-1:0] limit, // terminal count
	output wire hit, // tick while count is at limit minus one
	output wire [WIDTH-1:0] count // current count
);
	reg [WIDTH-1:0] cnt_ff;
	reg [WIDTH-1:0] nxt_cnt;

	always @* begin
		nxt_cnt = cnt_ff;
		if (clr) begin
			nxt_cnt = {WIDTH{1'b0}};
		end else if (tick) begin
			nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			cnt_ff <= {WIDTH{1'b0}};
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign hit = tick && (cnt_ff == limit - {{(WIDTH-1){1'b0}}, 1'b1});
	assign count = cnt_ff;
endmodule

// >>> hw/dsadc_ctrl.v
// Purpose: control logic for a dual-slope converter with five inputs
// Assumes: comparator input synchronous to clk; analog switches outside
// Notes: start register and result register are this block's own
`timescale 1ns/1ps
`include "dsadc_regs.vh"
module dsadc_ctrl #(
	parameter CW = 13,
	parameter TICK_DIV = `DSADC_TICK_DIV
) (
	input wire clk, // system clock, 10 MHz
	input wire sys_rst, // sync reset, high
	input wire [3:0] addr, // register address
	input wire [15:0] wdata, // write data
	input wire wr, // write strobe
	input wire rd, // read strobe
	output reg [15:0] rdata, // read data, cycle after rd
	input wire cmp_out, // comparator polarity, high for positive
	output reg ref_gen_enable, // reference generator on
	output reg ref_adjust_enable, // internal adjustment on
	output reg [4:0] term_switch, // analog terminal switches on
	output reg [4:0] int_ref_switch, // terminal used as integrator reference
	output reg ref_volt_resistance, // select resistance reference
	output reg ref_volt_voltage, // select voltage reference
	output reg sw_gnd, // integrator input on ground (auto-zero)
	output reg sw_vin, // integrator input on selected terminal
	output reg sw_ref_pos, // integrator input on +reference
	output reg sw_ref_neg, // integrator input on -reference
	output reg sw_autozero // auto-zero switches closed
);
	// ************************************
	// state
	// ************************************
	localparam S_IDLE = 4'b0001;
	localparam S_AZ = 4'b0010;
	localparam S_INT = 4'b0100;
	localparam S_REV = 4'b1000;

	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [4:0] input_terminal_sel_ff;
	reg [3:0] measure_type_sel_ff;
	reg resolution_sel_hi_ff;
	reg resolution_sel_lo_ff;
	reg ref_en_ff;
	reg ref_adj_ff;
	reg [4:0] cv_term_ff;
	reg [3:0] cv_type_ff;
	reg [1:0] cv_res_ff;
	reg pol_ff;
	reg done_ff;
	reg [CW-1:0] result_ff;
	reg [15:0] div_ff;
	reg tick_ff;
	reg [CW-1:0] limit;
	reg [CW-1:0] full_cnt;
	wire busy;
	wire start_wr;
	wire cnt_hit;
	wire [CW-1:0] cnt_val;
	wire cnt_clr;
	reg [4:0] nxt_term_switch;
	reg [4:0] nxt_int_ref_switch;
	reg nxt_ref_volt_resistance;
	reg nxt_ref_volt_voltage;
	reg nxt_ref_gen_enable;
	reg nxt_ref_adjust_enable;
	reg nxt_sw_gnd;
	reg nxt_sw_vin;
	reg nxt_sw_ref_pos;
	reg nxt_sw_ref_neg;

	assign busy = (state_ff != S_IDLE);
	assign start_wr = wr && (addr == `DSADC_OFF_START) && wdata[0];

	// ************************************
	// 32 kHz tick from system clock
	// ************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			div_ff <= 16'h0000;
			tick_ff <= 1'b0;
		end else if (div_ff == TICK_DIV[15:0] - 16'h0001) begin
			div_ff <= 16'h0000;
			tick_ff <= 1'b1;
		end else begin
			div_ff <= div_ff + 16'h0001;
			tick_ff <= 1'b0;
		end
	end

	// ************************************
	// software registers
	// ************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			ref_en_ff <= 1'b0;
			ref_adj_ff <= 1'b0;
			resolution_sel_lo_ff <= 1'b0;
			resolution_sel_hi_ff <= 1'b0;
			input_terminal_sel_ff <= `DSADC_TERM_RST;
			measure_type_sel_ff <= `DSADC_TYPE_RST;
		end else if (wr && addr == `DSADC_OFF_CTRL) begin
			ref_en_ff <= wdata[`DSADC_CTRL_REF_EN];
			ref_adj_ff <= wdata[`DSADC_CTRL_REF_ADJ];
			resolution_sel_lo_ff <= wdata[`DSADC_CTRL_RES_LO];
			resolution_sel_hi_ff <= wdata[`DSADC_CTRL_RES_HI];
		end else if (wr && addr == `DSADC_OFF_SEL) begin
			input_terminal_sel_ff <= wdata[`DSADC_SEL_TERM_LSB +: 5];
			measure_type_sel_ff <= wdata[`DSADC_SEL_TYPE_LSB +: 4];
		end
	end

	// ************************************
	// latched conversion settings
	// ************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			cv_term_ff <= 5'h00;
			cv_type_ff <= 4'h0;
			cv_res_ff <= 2'h0;
		end else if (start_wr && !busy) begin
			cv_term_ff <= input_terminal_sel_ff;
			cv_type_ff <= measure_type_sel_ff;
			cv_res_ff <= {resolution_sel_hi_ff, resolution_sel_lo_ff};
		end
	end

	// ************************************
	// resolution and phase lengths
	// ************************************
	always @* begin
		case (cv_res_ff)
			2'b00: full_cnt = `DSADC_RES_CNT0;
			2'b01: full_cnt = `DSADC_RES_CNT1;
			2'b10: full_cnt = `DSADC_RES_CNT2;
			default: full_cnt = `DSADC_RES_CNT3;
		endcase
		case (state_ff)
			S_AZ: limit = full_cnt;
			S_INT: limit = {1'b0, full_cnt[CW-1:1]};
			default: limit = full_cnt;
		endcase
	end

	assign cnt_clr = (state_ff == S_IDLE) || cnt_hit;

	dsadc_phase_cnt #(
		.WIDTH(CW)
	) dsadc_phase_cnt_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.clr(cnt_clr),
		.tick(tick_ff),
		.limit(limit),
		.hit(cnt_hit),
		.count(cnt_val)
	);

	// ************************************
	// phase sequence
	// ************************************
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (start_wr) begin
					nxt_state = S_AZ;
				end
			end
			S_AZ: begin
				if (cnt_hit) begin
					nxt_state = S_INT;
				end
			end
			S_INT: begin
				if (cnt_hit) begin
					nxt_state = S_REV;
				end
			end
			S_REV: begin
				if (cnt_hit) begin
					nxt_state = S_IDLE;
				end
			end
			default: nxt_state = S_IDLE;
		endcase
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= S_IDLE;
			pol_ff <= 1'b0;
			done_ff <= 1'b0;
			result_ff <= {CW{1'b0}};
		end else begin
			state_ff <= nxt_state;
			if (state_ff == S_INT && tick_ff) begin
				pol_ff <= cmp_out;
			end
			if (state_ff == S_REV && cnt_hit) begin
				done_ff <= 1'b1;
			end else if (start_wr && !busy) begin
				done_ff <= 1'b0;
			end
			if (state_ff == S_REV && tick_ff) begin
				result_ff <= cnt_val + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

	// ************************************
	// analog switch control
	// ************************************
	always @* begin
		nxt_term_switch = cv_term_ff & {5{busy}};
		nxt_int_ref_switch = 5'h00;
		nxt_ref_volt_resistance = 1'b0;
		nxt_ref_volt_voltage = 1'b0;
		case (cv_type_ff)
			4'b0001: nxt_int_ref_switch = 5'h01;
			4'b0010: nxt_int_ref_switch = 5'h04;
			4'b0100: nxt_int_ref_switch = 5'h10;
			4'b1000: nxt_int_ref_switch = 5'h10;
			default: nxt_int_ref_switch = 5'h00;
		endcase
		if (cv_type_ff[2] || cv_type_ff[3]) begin
			nxt_ref_volt_resistance = busy;
		end else begin
			nxt_ref_volt_voltage = busy;
		end
		nxt_int_ref_switch = nxt_int_ref_switch & {5{busy}};
		nxt_ref_gen_enable = ref_en_ff;
		nxt_ref_adjust_enable = ref_en_ff && ref_adj_ff;
		nxt_sw_gnd = (state_ff == S_AZ);
		nxt_sw_vin = (state_ff == S_INT);
		nxt_sw_ref_neg = (state_ff == S_REV) && pol_ff;
		nxt_sw_ref_pos = (state_ff == S_REV) && !pol_ff;
	end

	// switch drivers from flops, so no decode glitch reaches the analog side
	always @(posedge clk) begin
		if (sys_rst) begin
			term_switch <= 5'h00;
			int_ref_switch <= 5'h00;
			ref_volt_resistance <= 1'b0;
			ref_volt_voltage <= 1'b0;
			ref_gen_enable <= 1'b0;
			ref_adjust_enable <= 1'b0;
			sw_gnd <= 1'b0;
			sw_autozero <= 1'b0;
			sw_vin <= 1'b0;
			sw_ref_neg <= 1'b0;
			sw_ref_pos <= 1'b0;
		end else begin
			term_switch <= nxt_term_switch;
			int_ref_switch <= nxt_int_ref_switch;
			ref_volt_resistance <= nxt_ref_volt_resistance;
			ref_volt_voltage <= nxt_ref_volt_voltage;
			ref_gen_enable <= nxt_ref_gen_enable;
			ref_adjust_enable <= nxt_ref_adjust_enable;
			sw_gnd <= nxt_sw_gnd;
			sw_autozero <= nxt_sw_gnd;
			sw_vin <= nxt_sw_vin;
			sw_ref_neg <= nxt_sw_ref_neg;
			sw_ref_pos <= nxt_sw_ref_pos;
		end
	end

	// ************************************
	// register read
	// ************************************
	always @(posedge clk) begin
		if (sys_rst) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			case (addr)
				`DSADC_OFF_CTRL: rdata <= {12'h000, resolution_sel_hi_ff, resolution_sel_lo_ff,
					ref_adj_ff, ref_en_ff};
				`DSADC_OFF_SEL: rdata <= {7'h00, measure_type_sel_ff, input_terminal_sel_ff};
				`DSADC_OFF_STATUS: rdata <= {9'h000, state_ff, pol_ff, done_ff, busy};
				`DSADC_OFF_RESULT: rdata <= {{(16-CW){1'b0}}, result_ff};
				default: rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule

// >>> sim/dsadc_props.sv
// Purpose: port checker for the converter control block
// Assumes: one clock, sync reset high
// Notes: bound to dsadc_ctrl below
`timescale 1ns/1ps
module dsadc_props (
	input wire clk, // clock
	input wire sys_rst, // reset
	input wire ref_gen_enable, // ref on
	input wire ref_adjust_enable, // adjust on
	input wire [4:0] term_switch, // terminals
	input wire [4:0] int_ref_switch, // integrator ref
	input wire ref_volt_resistance, // resistance ref
	input wire ref_volt_voltage, // voltage ref
	input wire sw_gnd, // auto-zero input
	input wire sw_vin, // integration input
	input wire sw_ref_pos, // +ref
	input wire sw_ref_neg, // -ref
	input wire sw_autozero // auto-zero switches
);
	wire ph = sw_gnd | sw_vin | sw_ref_pos | sw_ref_neg;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ****
	// properties
	// ****
	a_reset_clear: assert property ($fell(sys_rst) |-> !ref_gen_enable && !ref_adjust_enable && !ph
		&& term_switch == 5'h00) else $error("controls not cleared by reset");
	a_adj_ref: assert property (ref_adjust_enable |-> ref_gen_enable)
		else $error("adjust on without reference");
	a_one_phase: assert property ($onehot0({sw_gnd, sw_vin, sw_ref_pos, sw_ref_neg}) && sw_autozero == sw_gnd)
		else $error("phase switches overlap");
	a_pol_hold: assert property ($past(sw_ref_neg) && ph |-> sw_ref_neg)
		else $error("reference polarity changed in reverse phase");
	a_sel_hold: assert property (ph && $past(ph) |-> $stable(term_switch) && $stable(int_ref_switch))
		else $error("selection changed mid-conversion");
	a_idle_dark: assert property (!ph |-> term_switch == 5'h00 && int_ref_switch == 5'h00
		&& !ref_volt_resistance && !ref_volt_voltage) else $error("switches on while idle");
	a_diff_low: assert property (ph && int_ref_switch != 5'h00 && !ref_volt_resistance
		|-> int_ref_switch == (term_switch & ~(term_switch - 5'h01))) else $error("bad differential ref");
	a_res_ref: assert property (ph && ref_volt_resistance |-> int_ref_switch == 5'h10 && !ref_volt_voltage)
		else $error("bad resistance ref");
	a_az_first: assert property ($rose(ph) |-> sw_gnd ##1 sw_gnd)
		else $error("conversion did not open with auto-zero");
endmodule
bind dsadc_ctrl dsadc_props dsadc_props_inst (.clk(clk), .sys_rst(sys_rst), .ref_gen_enable(ref_gen_enable),
	.ref_adjust_enable(ref_adjust_enable), .term_switch(term_switch), .int_ref_switch(int_ref_switch),
	.ref_volt_resistance(ref_volt_resistance), .ref_volt_voltage(ref_volt_voltage), .sw_gnd(sw_gnd),
	.sw_vin(sw_vin), .sw_ref_pos(sw_ref_pos), .sw_ref_neg(sw_ref_neg), .sw_autozero(sw_autozero));

// >>> sim/dsadc_sensor.sv
// Purpose: comparator side model for the selected input
// Assumes: polarity fixed per conversion by the bench
// Notes: toggles outside conversions so no stale level shows
`timescale 1ns/1ps
module dsadc_sensor (
	input wire clk, // clock
	input wire [4:0] term_switch, // terminals in use
	input wire pol, // input polarity wanted
	output logic cmp_out // comparator level
);
	logic tgl = 1'b0;
	always @(posedge clk) tgl <= ~tgl;
	assign cmp_out = (term_switch != 5'h00) ? pol : tgl;
endmodule

// >>> sim/dual_slope_adc_control_tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: short tick divider of 2 clocks
// Notes: nine legal selections, all four resolution codes
`timescale 1ns/1ps
module dual_slope_adc_control_tb;
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [3:0] addr = 4'h0;
	reg [15:0] wdata = 16'h0000;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg pol = 1'b0;
	wire [15:0] rdata;
	wire cmp_out, ref_gen_enable, ref_adjust_enable, ref_volt_resistance, ref_volt_voltage;
	wire sw_gnd, sw_vin, sw_ref_pos, sw_ref_neg, sw_autozero;
	wire [4:0] term_switch, int_ref_switch;
	integer n_errors = 0;
	integer comparisons = 0;
	integer cyc = 0;
	integer i;
	reg [15:0] d;
	reg [8:0] combos [0:8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h023, 9'h04c, 9'h094, 9'h118};
	always #50 clk = ~clk;
	dsadc_ctrl #(.TICK_DIV(2)) dsadc_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .cmp_out(cmp_out), .ref_gen_enable(ref_gen_enable),
		.ref_adjust_enable(ref_adjust_enable), .term_switch(term_switch), .int_ref_switch(int_ref_switch),
		.ref_volt_resistance(ref_volt_resistance), .ref_volt_voltage(ref_volt_voltage), .sw_gnd(sw_gnd),
		.sw_vin(sw_vin), .sw_ref_pos(sw_ref_pos), .sw_ref_neg(sw_ref_neg), .sw_autozero(sw_autozero));
	dsadc_sensor dsadc_sensor_inst (.clk(clk), .term_switch(term_switch), .pol(pol), .cmp_out(cmp_out));
	// ****
	// helpers
	// ****
	function [15:0] res_n(input [1:0] c);
		res_n = (c == 2'h3) ? 16'h0334 : 16'h1998 >> c;
	endfunction
	function [4:0] ref_exp(input [3:0] t);
		ref_exp = t[0] ? 5'h01 : t[1] ? 5'h04 : (t[2] | t[3]) ? 5'h10 : 5'h00;
	endfunction
	task stop_test;
		begin
			if (n_errors == 0 && comparisons > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [8*10-1:0] nm, input [15:0] got, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task wr_reg(input [3:0] a, input [15:0] v);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= v;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rd_reg(input [3:0] a, output [15:0] v);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 v = rdata;
		end
	endtask
	// one conversion, with selection and control rewritten mid-run
	task run(input [8:0] s, input [1:0] c);
		integer az, vi, seen, n;
		begin
			az = 0;
			vi = 0;
			seen = 0;
			n = res_n(c);
			@(posedge clk);
			pol <= 1'($urandom);
			wr_reg(4'h1, {7'h00, s});
			wr_reg(4'h0, {12'h000, c, 2'b01});
			wr_reg(4'h2, 16'h0001);
			wr_reg(4'h1, 16'($urandom));
			wr_reg(4'h0, 16'($urandom));
			do begin
				@(negedge clk);
				az = az + sw_gnd;
				vi = vi + sw_vin;
				if ((sw_ref_pos | sw_ref_neg) && seen == 0) begin
					seen = 1;
					chk("term", term_switch, s[4:0]);
					chk("intref", int_ref_switch, ref_exp(s[8:5]));
					chk("resref", ref_volt_resistance, |s[8:7]);
					chk("negref", sw_ref_neg, pol);
					chk("posref", sw_ref_pos, !pol);
					chk("volref", ref_volt_voltage, ~|s[8:7]);
				end
			end while (sw_gnd | sw_vin | sw_ref_pos | sw_ref_neg);
			chk("az_len", (az + 6 >= 2 * n) && (az <= 2 * n + 2), 1'b1);
			chk("int_len", (vi + 2 >= n) && (vi <= n + 2), 1'b1);
			chk("idle_term", term_switch, 5'h00);
			rd_reg(4'h4, d);
			chk("result", d, res_n(c));
			rd_reg(4'h3, d);
			chk("status", d[1:0], 2'b10);
		end
	endtask
	// ****
	// sequence
	// ****
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			n_errors = n_errors + 1;
			stop_test;
		end
	end
	initial begin
		void'($urandom(32'hb540));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd_reg(4'h0, d);
		chk("ctrl_rst", d, 16'h0000);
		rd_reg(4'h1, d);
		chk("sel_rst", d, 16'h0000);
		rd_reg(4'hf, d);
		chk("unmapped", d, 16'h0000);
		wr_reg(4'h0, 16'h0003);
		@(posedge clk);
		#1 chk("adj_on", ref_adjust_enable, 1'b1);
		wr_reg(4'h0, 16'h0002);
		@(posedge clk);
		#1 chk("ref_off", {ref_gen_enable, ref_adjust_enable}, 2'b00);
		for (i = 0; i < 9; i = i + 1)
			run(combos[i], (i < 3) ? i[1:0] : 2'h3);
		stop_test;
	end
endmodule
